// ### cfa_card_cmd.sv
// card command interpreter: retry query, file suspend/resume, chained authentication
// Function
// - unlock-code query with empty data answers 63CX, X the retries left
// - query accepted whether the personal code or the unlock code is blocked
// - query on a blocked unlock code answers 63C0 or 6983
// - suspend only when its access condition holds; sets life-cycle flag
// - successful suspend or resume makes the target the current file
// - failed suspend or resume leaves current file and folder untouched
// - suspended file without keep bit allows only select and resume
// - suspended file with keep bit stays readable and updatable
// - P2 zero; P1 00 by id, 08 from root, 09 from current folder
// - P1 and P2 zero with no data targets the current file
// - resume clears suspension only when its access condition holds
// - odd code optional; its data is always TLV wrapped
// - odd-code objects use tag 73 structured, 53 otherwise
// - data arrives in blocks of at most 255 bytes, joined here
// - 63F1 while data segments outstanding, 62F3 when complete
// - first response block request starts the computation
// - 62F1 while response segments remain, 9000 after the last
// - P1 bits b8..b6 give block type, b5..b1 algorithm
// - unlock retry counter starts at ten, blocks at zero
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cfa_card_cmd #(
    parameter int FILES = 4,
    parameter bit ODD_AUTH = 1'b1
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire cfa_pkg::cfa_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import cfa_pkg::*;
    localparam int IW = $clog2(FILES);

    logic [15:0] fid [FILES];
    logic [7:0] parent_df [FILES];
    logic [FILES-1:0] present, keep_rw, ac_susp, ac_res, susp;
    logic [FILES-1:0] usable;
    logic [IW-1:0] cur_ef;
    logic cur_ef_ok;
    logic [7:0] cur_df;
    logic [3:0] retry;
    logic [15:0] sw;
    logic [15:0] arg_fid;
    logic [7:0] arg_tag;
    logic [15:0] auth_total, resp_len, joined, resp_rem;
    logic [7:0] last_rx, last_tx;
    cfa_auth_st_t auth_st;
    cfa_cmd_t cmd;
    logic cmd_go;

    logic access, setup, wr, mapped;
    logic [31:0] next_prdata;
    logic sel_ok, use_cur, hit;
    logic [IW-1:0] tgt;
    logic [2:0] blk;
    logic [7:0] le_eff, send;
    logic rx_done;

    assign access = apb_i.psel & apb_i.penable;
    assign setup = apb_i.psel & ~apb_i.penable;
    assign wr = access & apb_i.pwrite;
    assign pready_o = access;
    assign pslverr_o = access & ~mapped;

    always_comb begin
        case (apb_i.paddr)
            OFF_CMD, OFF_ARG, OFF_STATUS, OFF_FILE, OFF_AUTH_CFG,
            OFF_AUTH_STAT, OFF_UNLOCK, OFF_FOLDER: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // a present file is usable for read/update unless suspended without the keep bit
    always_comb begin
        for (int i = 0; i < FILES; i++) begin
            usable[i] = present[i] & (~susp[i] | keep_rw[i]);
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (apb_i.paddr)
            OFF_CMD: next_prdata = cmd;
            OFF_ARG: next_prdata = {8'h00, arg_tag, arg_fid};
            OFF_STATUS: next_prdata = {cur_df, 3'b000, cur_ef_ok, 4'(cur_ef), sw};
            OFF_FILE: next_prdata = {16'h0000, 8'(usable), 8'(susp)};
            OFF_AUTH_CFG: next_prdata = {resp_len, auth_total};
            OFF_AUTH_STAT: next_prdata = {resp_rem, joined};
            OFF_UNLOCK: next_prdata = {28'h000_0000, retry};
            OFF_FOLDER: next_prdata = {14'h0000, auth_st, last_rx, last_tx};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // read data is captured in the setup cycle so it is stable for the access phase
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup && !apb_i.pwrite) begin
            prdata_o <= next_prdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cmd <= '0;
            cmd_go <= 1'b0;
            arg_fid <= 16'h0000;
            arg_tag <= 8'h00;
            auth_total <= 16'h0000;
            resp_len <= 16'h0000;
            cur_df <= 8'h00;
        end else begin
            cmd_go <= wr && apb_i.paddr == OFF_CMD;
            if (wr && apb_i.paddr == OFF_CMD) begin
                cmd <= apb_i.pwdata;
            end
            if (wr && apb_i.paddr == OFF_ARG) begin
                arg_fid <= apb_i.pwdata[15:0];
                arg_tag <= apb_i.pwdata[23:16];
            end
            if (wr && apb_i.paddr == OFF_AUTH_CFG) begin
                auth_total <= apb_i.pwdata[15:0];
                resp_len <= apb_i.pwdata[31:16];
            end
            if (wr && apb_i.paddr == OFF_FOLDER) begin
                cur_df <= apb_i.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            present <= '0;
            keep_rw <= '0;
            ac_susp <= '0;
            ac_res <= '0;
            for (int i = 0; i < FILES; i++) begin
                fid[i] <= 16'h0000;
                parent_df[i] <= 8'h00;
            end
        end else if (wr && apb_i.paddr == OFF_FILE) begin
            fid[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[15:0];
            parent_df[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[FC_DF_LSB +: 8];
            present[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[FC_PRESENT];
            keep_rw[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[FC_KEEP_RW];
            ac_susp[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[FC_AC_SUSP];
            ac_res[apb_i.pwdata[FC_IDX_LSB +: IW]] <= apb_i.pwdata[FC_AC_RES];
        end
    end

    // wrong presentations are reported by the verify path; the counter saturates at zero
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            retry <= RETRY_INIT;
        end else if (wr && apb_i.paddr == OFF_UNLOCK) begin
            if (apb_i.pwdata[UL_RESET]) begin
                retry <= RETRY_INIT;
            end else if (apb_i.pwdata[UL_WRONG] && retry != 4'h0) begin
                retry <= retry - 4'h1;
            end
        end
    end

    // target resolution; a path is reduced to its last file id by the caller
    always_comb begin
        sel_ok = cmd.p2 == 8'h00 && (cmd.p1 == SEL_BY_FID || cmd.p1 == SEL_FROM_ROOT
                 || cmd.p1 == SEL_FROM_CUR);
        use_cur = cmd.p1 == SEL_BY_FID && cmd.lc == 8'h00;
        hit = 1'b0;
        tgt = cur_ef;
        if (use_cur) begin
            hit = cur_ef_ok & present[cur_ef];
        end else begin
            for (int i = FILES - 1; i >= 0; i--) begin
                if (present[i] && fid[i] == arg_fid
                    && (cmd.p1 == SEL_FROM_ROOT || parent_df[i] == cur_df)) begin
                    hit = 1'b1;
                    tgt = IW'(i);
                end
            end
        end
    end

    assign blk = cmd.p1[7:5];
    assign le_eff = (cmd.lc == 8'h00) ? MAX_BLOCK : cmd.lc;
    assign send = (resp_rem > 16'(le_eff)) ? le_eff : resp_rem[7:0];
    assign rx_done = joined >= auth_total;

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sw <= SW_RESET;
            susp <= '0;
            cur_ef <= '0;
            cur_ef_ok <= 1'b0;
            auth_st <= CFA_IDLE;
            joined <= 16'h0000;
            resp_rem <= 16'h0000;
            last_rx <= 8'h00;
            last_tx <= 8'h00;
        end else if (wr && apb_i.paddr == OFF_FILE) begin
            susp[apb_i.pwdata[FC_IDX_LSB +: IW]] <= 1'b0;
        end else if (cmd_go) begin
            case (cmd.kind)
                CFA_UNLOCK: begin
                    // answered whatever the personal code's state
                    if (cmd.p1 != 8'h00) begin
                        sw <= SW_BAD_P1P2;
                    end else if (cmd.lc == UNLOCK_DATA_LEN) begin
                        sw <= SW_NO_FUNC;
                    end else if (cmd.lc != 8'h00) begin
                        sw <= SW_BAD_LEN;
                    end else if (retry == 4'h0) begin
                        sw <= SW_CODE_BLOCKED;
                    end else begin
                        sw <= {SW_RETRY_HI, retry};
                    end
                end
                CFA_SUSPEND, CFA_RESUME: begin
                    // every failure below leaves cur_ef and cur_df alone
                    if (!sel_ok) begin
                        sw <= SW_BAD_P1P2;
                    end else if (!hit) begin
                        sw <= SW_NOT_FOUND;
                    end else if (cmd.kind == CFA_SUSPEND && !ac_susp[tgt]) begin
                        sw <= SW_AC_FAIL;
                    end else if (cmd.kind == CFA_RESUME && !ac_res[tgt]) begin
                        sw <= SW_AC_FAIL;
                    end else begin
                        susp[tgt] <= cmd.kind == CFA_SUSPEND;
                        cur_ef <= tgt;
                        cur_ef_ok <= 1'b1;
                        sw <= SW_OK;
                    end
                end
                default: begin
                    if (!cmd.odd) begin
                        // single exchange: plain challenge, response ready at once
                        if (cmd.p1 != 8'h00) begin
                            sw <= SW_BAD_P1P2;
                        end else begin
                            joined <= 16'(cmd.lc);
                            resp_rem <= 16'h0000;
                            auth_st <= CFA_IDLE;
                            sw <= SW_OK;
                        end
                    end else if (!ODD_AUTH) begin
                        sw <= SW_NO_FUNC;
                    end else if (arg_tag != TAG_TLV && arg_tag != TAG_RAW) begin
                        sw <= SW_BAD_DATA;
                    end else begin
                        case (blk)
                            BLK_FIRST_DATA: begin
                                joined <= 16'(cmd.lc);
                                last_rx <= cmd.lc;
                                auth_st <= CFA_RX;
                                sw <= (16'(cmd.lc) >= auth_total) ? SW_RX_DONE : SW_RX_MORE;
                            end
                            BLK_NEXT_DATA: begin
                                if (auth_st != CFA_RX || rx_done) begin
                                    sw <= SW_SEQUENCE;
                                end else begin
                                    joined <= joined + 16'(cmd.lc);
                                    last_rx <= cmd.lc;
                                    sw <= (joined + 16'(cmd.lc) >= auth_total)
                                        ? SW_RX_DONE : SW_RX_MORE;
                                end
                            end
                            BLK_RETX_DATA: begin
                                // replacement block overwrites the last one in place
                                if (auth_st != CFA_RX) begin
                                    sw <= SW_SEQUENCE;
                                end else begin
                                    joined <= joined - 16'(last_rx) + 16'(cmd.lc);
                                    last_rx <= cmd.lc;
                                    sw <= (joined - 16'(last_rx) + 16'(cmd.lc) >= auth_total)
                                        ? SW_RX_DONE : SW_RX_MORE;
                                end
                            end
                            BLK_FIRST_RESP: begin
                                // computation is launched here; its result length is resp_len
                                if (auth_st != CFA_RX || !rx_done) begin
                                    sw <= SW_SEQUENCE;
                                end else begin
                                    last_tx <= (resp_len > 16'(le_eff)) ? le_eff : resp_len[7:0];
                                    resp_rem <= (resp_len > 16'(le_eff))
                                        ? resp_len - 16'(le_eff) : 16'h0000;
                                    auth_st <= CFA_TX;
                                    sw <= (resp_len > 16'(le_eff)) ? SW_TX_MORE : SW_OK;
                                end
                            end
                            BLK_NEXT_RESP: begin
                                if (auth_st != CFA_TX || resp_rem == 16'h0000) begin
                                    sw <= SW_SEQUENCE;
                                end else begin
                                    last_tx <= send;
                                    resp_rem <= resp_rem - 16'(send);
                                    sw <= (resp_rem > 16'(send)) ? SW_TX_MORE : SW_OK;
                                end
                            end
                            BLK_RETX_RESP: begin
                                if (auth_st != CFA_TX) begin
                                    sw <= SW_SEQUENCE;
                                end else begin
                                    sw <= (resp_rem != 16'h0000) ? SW_TX_MORE : SW_OK;
                                end
                            end
                            default: sw <= SW_BAD_P1P2;
                        endcase
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_query;
        cmd_go && cmd.kind == CFA_UNLOCK && cmd.p1 == 8'h00 && cmd.lc == 8'h00;
    endsequence
    sequence s_file_cmd;
        cmd_go && (cmd.kind == CFA_SUSPEND || cmd.kind == CFA_RESUME);
    endsequence
    sequence s_file_fail;
        s_file_cmd ##1 sw != SW_OK;
    endsequence

    chk_retry_value: assert property (s_query and retry != 4'h0 |=> sw == {SW_RETRY_HI, $past(retry)})
        else $error("retry query status does not carry the counter");
    chk_query_blocked: assert property (s_query and retry == 4'h0 |=> sw == SW_CODE_BLOCKED)
        else $error("blocked unlock code not reported");
    chk_retry_bound: assert property (retry <= RETRY_INIT)
        else $error("retry counter above its initial value");
    chk_fail_keeps: assert property (s_file_fail |-> cur_ef == $past(cur_ef, 1)
        && cur_df == $past(cur_df, 1))
        else $error("failed file command moved the current file");
    chk_ok_current: assert property (s_file_cmd ##1 sw == SW_OK |-> cur_ef_ok
        && susp[cur_ef] == ($past(cmd.kind, 1) == CFA_SUSPEND))
        else $error("successful file command did not update target");
    chk_bad_select: assert property (s_file_cmd and !sel_ok |=> sw == SW_BAD_P1P2)
        else $error("reserved selection code accepted");
    chk_suspend_ac: assert property (s_file_cmd and hit and sel_ok and !ac_susp[tgt]
        and cmd.kind == CFA_SUSPEND |=> !$changed(susp))
        else $error("suspend executed without its access condition");
    chk_tx_status: assert property (cmd_go && cmd.odd && cmd.kind == CFA_AUTH
        ##1 sw == SW_TX_MORE |-> resp_rem != 16'h0000)
        else $error("62F1 given with nothing left to send");
    chk_rx_status: assert property (cmd_go && cmd.odd && cmd.kind == CFA_AUTH
        ##1 sw == SW_RX_MORE |-> joined < auth_total)
        else $error("63F1 given after all data arrived");
    chk_retx_hold: assert property (cmd_go && cmd.odd && cmd.kind == CFA_AUTH
        && blk == BLK_RETX_RESP |=> $stable(resp_rem))
        else $error("response retransmit advanced the position");
endmodule // cfa_card_cmd
`default_nettype wire

// ### cfa_pkg.sv
// package: register map, status words and command layout of the card command block
package cfa_pkg;
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFF_CMD = 8'h00;
    localparam logic [APB_AW-1:0] OFF_ARG = 8'h04;
    localparam logic [APB_AW-1:0] OFF_STATUS = 8'h08;
    localparam logic [APB_AW-1:0] OFF_FILE = 8'h0C;
    localparam logic [APB_AW-1:0] OFF_AUTH_CFG = 8'h10;
    localparam logic [APB_AW-1:0] OFF_AUTH_STAT = 8'h14;
    localparam logic [APB_AW-1:0] OFF_UNLOCK = 8'h18;
    localparam logic [APB_AW-1:0] OFF_FOLDER = 8'h1C;

    // file configuration word fields
    localparam int FC_IDX_LSB = 16;
    localparam int FC_PRESENT = 20;
    localparam int FC_KEEP_RW = 21;
    localparam int FC_AC_SUSP = 22;
    localparam int FC_AC_RES = 23;
    localparam int FC_DF_LSB = 24;
    // unlock register write bits
    localparam int UL_WRONG = 0;
    localparam int UL_RESET = 1;

    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_RX_MORE = 16'h63F1;
    localparam logic [15:0] SW_RX_DONE = 16'h62F3;
    localparam logic [15:0] SW_TX_MORE = 16'h62F1;
    localparam logic [11:0] SW_RETRY_HI = 12'h63C;
    localparam logic [15:0] SW_CODE_BLOCKED = 16'h6983;
    localparam logic [15:0] SW_AC_FAIL = 16'h6982;
    localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
    localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
    localparam logic [15:0] SW_BAD_DATA = 16'h6A80;
    localparam logic [15:0] SW_BAD_LEN = 16'h6700;
    localparam logic [15:0] SW_SEQUENCE = 16'h6985;
    localparam logic [15:0] SW_NO_FUNC = 16'h6A81;
    localparam logic [15:0] SW_RESET = 16'h0000;

    localparam logic [7:0] SEL_BY_FID = 8'h00;
    localparam logic [7:0] SEL_FROM_ROOT = 8'h08;
    localparam logic [7:0] SEL_FROM_CUR = 8'h09;

    localparam logic [2:0] BLK_FIRST_DATA = 3'b100;
    localparam logic [2:0] BLK_NEXT_DATA = 3'b000;
    localparam logic [2:0] BLK_RETX_DATA = 3'b010;
    localparam logic [2:0] BLK_FIRST_RESP = 3'b101;
    localparam logic [2:0] BLK_NEXT_RESP = 3'b001;
    localparam logic [2:0] BLK_RETX_RESP = 3'b011;

    localparam logic [7:0] TAG_TLV = 8'h73;
    localparam logic [7:0] TAG_RAW = 8'h53;
    localparam logic [7:0] UNLOCK_DATA_LEN = 8'h10;
    localparam logic [7:0] MAX_BLOCK = 8'hFF;
    localparam logic [3:0] RETRY_INIT = 4'hA;

    typedef enum logic [1:0] {CFA_UNLOCK, CFA_SUSPEND, CFA_RESUME, CFA_AUTH} cfa_kind_t;
    typedef enum logic [1:0] {CFA_IDLE, CFA_RX, CFA_TX} cfa_auth_st_t;

    typedef struct packed {
        logic [7:0] lc;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [4:0] unused;
        logic odd;
        cfa_kind_t kind;
    } cfa_cmd_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } cfa_apb_req_t;
endpackage

// ### cfa_term_model.sv
// terminal-side model: apb master that issues command and configuration words
`timescale 1ns/100ps
`default_nettype none
module cfa_term_model (
    input wire logic clock_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    output var cfa_pkg::cfa_apb_req_t req_o
);
    import cfa_pkg::*;

    initial req_o = '0;

    // the request stays frozen until pready is sampled high, as the slave may stall
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge clock_i);
        req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clock_i);
        req_o.penable <= 1'b1;
        // no wait limit here: only the bench timeout ends a stalled transfer
        do begin
            @(posedge clock_i);
        end while (pready_i !== 1'b1);
        rdata = prdata_i;
        req_o.psel <= 1'b0;
        req_o.penable <= 1'b0;
    endtask
endmodule // cfa_term_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the card command block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cfa_pkg::*;
    logic clock_i;
    logic rstn_i;
    cfa_apb_req_t apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err_seen;
    logic [31:0] rd;
    logic [15:0] fid [4];
    logic [7:0] bad_p1 [3] = '{8'h01, 8'h10, 8'h88};
    logic [15:0] tot;
    logic [15:0] rlen;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    cfa_card_cmd #(.FILES(4), .ODD_AUTH(1'b1)) cfa_card_cmd_i (.clock_i(clock_i),
        .rstn_i(rstn_i), .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
    cfa_term_model cfa_term_model_i (.clock_i(clock_i), .pready_i(pready),
        .prdata_i(prdata), .req_o(apb));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfa_term_model_i.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdr(input logic [7:0] a);
        cfa_term_model_i.xfer(1'b0, a, 32'h0, rd);
    endtask

    function automatic logic [31:0] cmd(input cfa_kind_t k, input logic odd,
                                        input logic [7:0] p1, input logic [7:0] p2,
                                        input logic [7:0] lc);
        cfa_cmd_t c;
        c = '{lc: lc, p2: p2, p1: p1, unused: 5'h0, odd: odd, kind: k};
        return c;
    endfunction

    // status word left by a command is read back in the very next transfer
    task automatic run(input logic [31:0] c, input logic [15:0] exp_sw);
        wr(OFF_CMD, c);
        rdr(OFF_STATUS);
        check("status word", {16'h0, rd[15:0]}, {16'h0, exp_sw});
    endtask

    function automatic logic [15:0] retry_sw(input int n);
        return (n == 0) ? SW_CODE_BLOCKED : {SW_RETRY_HI, 4'(n)};
    endfunction

    function automatic logic [31:0] fcfg(input int i, input logic keep, input logic acs);
        return {8'h00, 1'b1, acs, keep, 1'b1, 2'b00, 2'(i), fid[i]};
    endfunction

    function automatic logic [7:0] ap1(input logic [2:0] blk);
        return {blk, 5'h00};
    endfunction

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // error flag is captured at the edge that completes the access phase
    always @(posedge clock_i) begin
        if (pready === 1'b1) begin
            err_seen <= pslverr;
        end
    end

    initial begin
        rstn_i = 1'b0;
        void'($urandom(32'h0397));
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rdr(OFF_STATUS);
        check("reset status", {11'h0, rd[20:0]}, 32'h0);
        rdr(OFF_UNLOCK);
        check("reset retries", {28'h0, rd[3:0]}, {28'h0, RETRY_INIT});
        @(negedge clock_i);
        check("slave error", {31'h0, err_seen}, 32'h0);
        rdr(8'h40);
        check("unmapped read", rd, 32'h0);
        @(negedge clock_i);
        check("slave error", {31'h0, err_seen}, 32'h1);
        for (int k = 10; k >= 0; k--) begin
            run(cmd(CFA_UNLOCK, 1'b0, 8'h00, 8'($urandom_range(1, 8)), 8'h00), retry_sw(k));
            wr(OFF_UNLOCK, 32'h1);
        end
        run(cmd(CFA_UNLOCK, 1'b0, 8'h00, 8'h03, 8'h00), retry_sw(0));
        wr(OFF_UNLOCK, 32'h2);
        run(cmd(CFA_UNLOCK, 1'b0, 8'h00, 8'h01, 8'h05), SW_BAD_LEN);
        run(cmd(CFA_UNLOCK, 1'b0, 8'h00, 8'h01, UNLOCK_DATA_LEN), SW_NO_FUNC);
        run(cmd(CFA_UNLOCK, 1'b0, 8'h00, 8'h01, 8'h00), retry_sw(10));
        for (int i = 0; i < 4; i++) begin
            fid[i] = 16'(($urandom() & 32'h0FFF) | (i << 12));
            wr(OFF_FILE, fcfg(i, i == 1, i != 2));
        end
        wr(OFF_FOLDER, 32'h0);
        wr(OFF_ARG, {16'h0, fid[0]});
        run(cmd(CFA_SUSPEND, 1'b0, SEL_BY_FID, 8'h00, 8'h02), SW_OK);
        check("current file", {27'h0, rd[20:16]}, 32'h10);
        rdr(OFF_FILE);
        check("file flags", {20'h0, rd[11:0]}, 32'hE01);
        wr(OFF_ARG, {16'h0, fid[1]});
        run(cmd(CFA_SUSPEND, 1'b0, SEL_FROM_ROOT, 8'h00, 8'h04), SW_OK);
        rdr(OFF_FILE);
        check("file flags", {20'h0, rd[11:0]}, 32'hE03);
        wr(OFF_ARG, {16'h0, fid[2]});
        run(cmd(CFA_SUSPEND, 1'b0, SEL_FROM_CUR, 8'h00, 8'h04), SW_AC_FAIL);
        check("current kept", {rd[31:24], 19'h0, rd[20:16]}, 32'h11);
        foreach (bad_p1[j]) begin
            run(cmd(CFA_RESUME, 1'b0, bad_p1[j], 8'h00, 8'h02), SW_BAD_P1P2);
            check("current kept", {27'h0, rd[20:16]}, 32'h11);
        end
        run(cmd(CFA_SUSPEND, 1'b0, SEL_BY_FID, 8'h01, 8'h02), SW_BAD_P1P2);
        wr(OFF_ARG, 32'h0000_F000);
        run(cmd(CFA_SUSPEND, 1'b0, SEL_FROM_ROOT, 8'h00, 8'h02), SW_NOT_FOUND);
        check("current kept", {27'h0, rd[20:16]}, 32'h11);
        run(cmd(CFA_RESUME, 1'b0, 8'h00, 8'h00, 8'h00), SW_OK);
        rdr(OFF_FILE);
        check("file flags", {28'h0, rd[3:0]}, 32'h1);
        run(cmd(CFA_AUTH, 1'b0, 8'h00, 8'h00, 8'h10), SW_OK);
        run(cmd(CFA_AUTH, 1'b0, 8'h01, 8'h00, 8'h10), SW_BAD_P1P2);
        tot = 16'(256 + $urandom_range(0, 199));
        rlen = 16'(256 + $urandom_range(0, 199));
        wr(OFF_AUTH_CFG, {rlen, tot});
        wr(OFF_ARG, {8'h0, TAG_TLV, 16'h0});
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_FIRST_DATA), 8'h00, MAX_BLOCK), SW_RX_MORE);
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_RETX_DATA), 8'h00, MAX_BLOCK), SW_RX_MORE);
        rdr(OFF_AUTH_STAT);
        check("joined bytes", {16'h0, rd[15:0]}, 32'hFF);
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_NEXT_DATA), 8'h00, 8'(tot - 16'd255)), SW_RX_DONE);
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_FIRST_RESP), 8'h00, 8'h00), SW_TX_MORE);
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_RETX_RESP), 8'h00, 8'h00), SW_TX_MORE);
        rdr(OFF_AUTH_STAT);
        check("response left", {16'h0, rd[31:16]}, {16'h0, rlen - 16'd255});
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_NEXT_RESP), 8'h00, 8'h00), SW_OK);
        wr(OFF_ARG, {8'h0, 8'h11, 16'h0});
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_FIRST_DATA), 8'h00, 8'h10), SW_BAD_DATA);
        wr(OFF_ARG, {8'h0, TAG_RAW, 16'h0});
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_FIRST_DATA), 8'h00, 8'h10), SW_RX_MORE);
        run(cmd(CFA_AUTH, 1'b1, ap1(BLK_FIRST_RESP), 8'h00, 8'h00), SW_SEQUENCE);
        run(cmd(CFA_AUTH, 1'b1, ap1(3'h6), 8'h00, 8'h00), SW_BAD_P1P2);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
